// ===== common/pcs_pkg.sv
// Purpose: Shared constants and types for the program counter, stack
//          and indirect access block.
// Assumes: One core clock, asynchronous active-low reset.
// Notes:   Data-space addresses are compared on their low seven bits.
package pcs_pkg;

	// Program counter and paging
	localparam int PC_W      = 13;
	localparam int TGT_W     = 11;
	localparam int DW        = 8;
	localparam int LATCH_W   = 5;
	localparam int PAGE_LO   = 3;
	localparam int EA_W      = 9;
	localparam int DADR_W    = 8;
	localparam int MATCH_W   = 7;

	// Return stack
	localparam int STK_DEPTH = 8;
	localparam int STK_PTR_W = 3;

	// Data-space register addresses
	localparam logic [MATCH_W-1:0] ADR_INDIRECT = 7'h00;
	localparam logic [MATCH_W-1:0] ADR_PC_LOW   = 7'h02;
	localparam logic [MATCH_W-1:0] ADR_PTR      = 7'h04;
	localparam logic [MATCH_W-1:0] ADR_LATCH    = 7'h0a;

	localparam logic [PC_W-1:0]    PC_RESET     = 13'h0000;
	localparam logic [PC_W-1:0]    PC_STEP      = 13'h0001;
	localparam logic [PC_W-1:0]    IRQ_VECTOR   = 13'h0004;
	localparam logic [DW-1:0]      SELF_RDATA   = 8'h00;
	localparam logic [DW-1:0]      PTR_RESET    = 8'h00;
	localparam logic [LATCH_W-1:0] LATCH_RESET  = 5'h00;

	// Register bus
	localparam int AXI_AW  = 4;
	localparam int AXI_DW  = 32;
	localparam int REG_N   = 3;
	localparam int REG_IW  = 2;
	localparam logic [REG_IW-1:0] IDX_CTRL     = 2'h0;
	localparam logic [REG_IW-1:0] IDX_PC_STAT  = 2'h1;
	localparam logic [REG_IW-1:0] IDX_PTR_STAT = 2'h2;
	localparam int CTRL_RUN_BIT   = 0;
	localparam int STAT_LATCH_LSB = 16;
	localparam int STAT_LAST_LSB  = 8;
	localparam logic [AXI_DW-1:0] CTRL_RESET  = 32'h0000_0001;
	localparam logic [1:0]        RESP_OKAY   = 2'h0;
	localparam logic [1:0]        RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_NONE, OP_NEXT, OP_GOTO, OP_CALL,
		OP_IRQ, OP_RET, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT
	} pcs_op_type;

	typedef struct packed {
		logic              valid;
		logic              wr;
		logic [DADR_W-1:0] addr;
		logic [DW-1:0]     wdata;
	} pcs_acc_type;

	typedef struct packed {
		logic            valid;
		logic            wr;
		logic [EA_W-1:0] addr;
		logic            own;
		logic [DW-1:0]   rdata;
	} pcs_res_type;

	typedef struct packed {
		logic              en;
		logic [REG_IW-1:0] idx;
		logic [AXI_DW-1:0] data;
		logic [3:0]        strb;
	} pcs_regwr_type;

endpackage

// ===== rtl/pcs_axil_regs.sv
// Purpose: AXI4-Lite slave that hands register writes and reads on.
// Assumes: Register values arrive as a packed word per index.
// Notes:   Only the control word is writable; others answer SLVERR.
`timescale 1ns/1ps
module pcs_axil_regs (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst_n,
	input  wire logic [pcs_pkg::AXI_AW-1:0]  i_awaddr,
	input  wire logic                        i_awvalid,
	output logic                             o_awready,
	input  wire logic [pcs_pkg::AXI_DW-1:0]  i_wdata,
	input  wire logic [3:0]                  i_wstrb,
	input  wire logic                        i_wvalid,
	output logic                             o_wready,
	output logic [1:0]                       o_bresp,
	output logic                             o_bvalid,
	input  wire logic                        i_bready,
	input  wire logic [pcs_pkg::AXI_AW-1:0]  i_araddr,
	input  wire logic                        i_arvalid,
	output logic                             o_arready,
	output logic [pcs_pkg::AXI_DW-1:0]       o_rdata,
	output logic [1:0]                       o_rresp,
	output logic                             o_rvalid,
	input  wire logic                        i_rready,
	input  wire logic [pcs_pkg::REG_N-1:0][pcs_pkg::AXI_DW-1:0] i_regs,
	output pcs_pkg::pcs_regwr_type           o_wr
);
	import pcs_pkg::*;

	typedef struct packed {
		logic              aw_have, w_have, awrdy, wrdy, bvalid;
		logic [1:0]        bresp;
		logic [AXI_AW-1:0] awaddr;
		logic [AXI_DW-1:0] wdata;
		logic [3:0]        wstrb;
		logic              arrdy, rvalid;
		logic [1:0]        rresp;
		logic [AXI_DW-1:0] rdata;
		pcs_regwr_type     wr;
	} pcs_axs_type;

	pcs_axs_type s_r;
	pcs_axs_type s_nxt;

	function automatic logic [REG_IW-1:0] reg_idx(logic [AXI_AW-1:0] a);
		return a[AXI_AW-1:2];
	endfunction

	function automatic logic idx_ok(logic [AXI_AW-1:0] a);
		return reg_idx(a) < REG_IW'(REG_N);
	endfunction

	always_comb begin
		s_nxt       = s_r;
		s_nxt.wr.en = 1'b0;
		if (i_awvalid && s_r.awrdy) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.awaddr  = i_awaddr;
		end
		if (i_wvalid && s_r.wrdy) begin
			s_nxt.w_have = 1'b1;
			s_nxt.wdata  = i_wdata;
			s_nxt.wstrb  = i_wstrb;
		end
		if (s_r.bvalid && i_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_nxt.aw_have && s_nxt.w_have && !s_nxt.bvalid) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			if (reg_idx(s_nxt.awaddr) == IDX_CTRL) begin
				s_nxt.bresp   = RESP_OKAY;
				s_nxt.wr.en   = 1'b1;
				s_nxt.wr.idx  = IDX_CTRL;
				s_nxt.wr.data = s_nxt.wdata;
				s_nxt.wr.strb = s_nxt.wstrb;
			end else begin
				s_nxt.bresp = RESP_SLVERR;
			end
		end
		s_nxt.awrdy = !s_nxt.aw_have && !s_nxt.bvalid;
		s_nxt.wrdy  = !s_nxt.w_have && !s_nxt.bvalid;
		if (s_r.rvalid && i_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (i_arvalid && s_r.arrdy) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = idx_ok(i_araddr) ? RESP_OKAY : RESP_SLVERR;
			s_nxt.rdata  = idx_ok(i_araddr) ? i_regs[reg_idx(i_araddr)]
				: '0;
		end
		s_nxt.arrdy = !s_nxt.rvalid;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_awready = s_r.awrdy;
	assign o_wready  = s_r.wrdy;
	assign o_bvalid  = s_r.bvalid;
	assign o_bresp   = s_r.bresp;
	assign o_arready = s_r.arrdy;
	assign o_rvalid  = s_r.rvalid;
	assign o_rresp   = s_r.rresp;
	assign o_rdata   = s_r.rdata;
	assign o_wr      = s_r.wr;

endmodule // pcs_axil_regs

// ===== rtl/pcs_core.sv
// Purpose: Program counter, page latch, return stack and indirect
//          data access for an 8-bit core.
// Assumes: Decoder presents at most one flow operation per cycle.
// Notes:   Access answers appear one cycle after the request.
`timescale 1ns/1ps
module pcs_core #(
	parameter bit BANK_USED = 1'b0
) (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst_n,
	input  pcs_pkg::pcs_op_type              i_op,
	input  wire logic [pcs_pkg::TGT_W-1:0]   i_target,
	input  pcs_pkg::pcs_acc_type             i_acc,
	input  wire logic                        i_bank_bit,
	output logic [pcs_pkg::PC_W-1:0]         o_pc,
	output pcs_pkg::pcs_res_type             o_res,
	input  wire logic [pcs_pkg::AXI_AW-1:0]  i_awaddr,
	input  wire logic                        i_awvalid,
	output logic                             o_awready,
	input  wire logic [pcs_pkg::AXI_DW-1:0]  i_wdata,
	input  wire logic [3:0]                  i_wstrb,
	input  wire logic                        i_wvalid,
	output logic                             o_wready,
	output logic [1:0]                       o_bresp,
	output logic                             o_bvalid,
	input  wire logic                        i_bready,
	input  wire logic [pcs_pkg::AXI_AW-1:0]  i_araddr,
	input  wire logic                        i_arvalid,
	output logic                             o_arready,
	output logic [pcs_pkg::AXI_DW-1:0]       o_rdata,
	output logic [1:0]                       o_rresp,
	output logic                             o_rvalid,
	input  wire logic                        i_rready
);
	import pcs_pkg::*;

	// Flow state
	logic [PC_W-1:0]    pc_r;
	logic [PC_W-1:0]    pc_nxt;
	logic [LATCH_W-1:0] latch_r;
	logic [LATCH_W-1:0] latch_nxt;
	logic [DW-1:0]      ptr_r;
	logic [DW-1:0]      ptr_nxt;

	// Access answer and software view
	pcs_res_type        res_r;
	pcs_res_type        res_nxt;
	logic [AXI_DW-1:0]  ctrl_r;
	logic [AXI_DW-1:0]  ctrl_nxt;
	logic [EA_W-1:0]    last_ea_r;
	logic [EA_W-1:0]    last_ea_nxt;

	// Decode
	logic               run;
	logic               is_ind;
	logic               self_hit;
	logic [EA_W-1:0]    ea;
	logic               wr_ok;
	logic               pcl_wr;
	logic               latch_wr;
	logic               ptr_wr;
	logic               push;
	logic               pop;
	logic [PC_W-1:0]    stk_top;
	logic [REG_N-1:0][AXI_DW-1:0] regs;
	pcs_regwr_type      regwr;

	function automatic logic adr_is(logic [EA_W-1:0] a,
		logic [MATCH_W-1:0] r);
		return a[MATCH_W-1:0] == r;
	endfunction

	function automatic logic is_ret(pcs_op_type op);
		return op == OP_RET || op == OP_RETURN_WITH_LITERAL || op == OP_RETURN_FROM_INTERRUPT;
	endfunction

	assign run = ctrl_r[CTRL_RUN_BIT];

	// Indirect address resolution
	always_comb begin
		is_ind = adr_is(EA_W'(i_acc.addr), ADR_INDIRECT);
		ea     = EA_W'(i_acc.addr);
		if (is_ind) begin
			ea = {BANK_USED ? i_bank_bit : 1'b0, ptr_r};
		end
		self_hit = is_ind && adr_is(ea, ADR_INDIRECT);
		// Self-targeted write is dropped before any register sees it
		wr_ok    = i_acc.valid && i_acc.wr && !self_hit;
		pcl_wr   = wr_ok && adr_is(ea, ADR_PC_LOW);
		latch_wr = wr_ok && adr_is(ea, ADR_LATCH);
		ptr_wr   = wr_ok && adr_is(ea, ADR_PTR);
	end

	// Stack handshake; a low-byte write cancels the operation
	assign push = run && !pcl_wr && (i_op == OP_CALL || i_op == OP_IRQ);
	assign pop  = run && !pcl_wr && is_ret(i_op);

	pcs_ret_stack #(
		.DEPTH (STK_DEPTH),
		.PTR_W (STK_PTR_W),
		.W     (PC_W)
	) u_stack (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_push  (push),
		.i_pop   (pop),
		.i_data  (pc_r),
		.o_top   (stk_top)
	);

	// Program counter next value
	always_comb begin
		pc_nxt = pc_r;
		if (pcl_wr) begin
			pc_nxt = {latch_r, i_acc.wdata};
		end else if (run) begin
			unique case (i_op)
				OP_NONE:   pc_nxt = pc_r;
				OP_NEXT:   pc_nxt = pc_r + PC_STEP;
				OP_GOTO,
				OP_CALL:   pc_nxt = {latch_r[LATCH_W-1:PAGE_LO],
					i_target};
				OP_IRQ:    pc_nxt = IRQ_VECTOR;
				OP_RET,
				OP_RETURN_WITH_LITERAL,
				OP_RETURN_FROM_INTERRUPT: pc_nxt = stk_top;
			endcase
		end
	end

	// Latch and pointer change only on data writes, never on stack use
	always_comb begin
		latch_nxt = latch_r;
		ptr_nxt   = ptr_r;
		if (latch_wr) begin
			latch_nxt = i_acc.wdata[LATCH_W-1:0];
		end
		if (ptr_wr) begin
			ptr_nxt = i_acc.wdata;
		end
	end

	// Access answer, one cycle after the request
	always_comb begin
		res_nxt       = '0;
		last_ea_nxt   = last_ea_r;
		res_nxt.valid = i_acc.valid;
		res_nxt.wr    = wr_ok;
		res_nxt.addr  = ea;
		res_nxt.rdata = SELF_RDATA;
		if (i_acc.valid) begin
			last_ea_nxt = ea;
		end
		if (self_hit) begin
			res_nxt.own   = 1'b1;
			res_nxt.rdata = SELF_RDATA;
		end else if (adr_is(ea, ADR_PC_LOW)) begin
			res_nxt.own   = 1'b1;
			res_nxt.rdata = pc_r[DW-1:0];
		end else if (adr_is(ea, ADR_LATCH)) begin
			res_nxt.own   = 1'b1;
			res_nxt.rdata = DW'(latch_r);
		end else if (adr_is(ea, ADR_PTR)) begin
			res_nxt.own   = 1'b1;
			res_nxt.rdata = ptr_r;
		end
	end

	// Software control word
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (regwr.en && regwr.idx == IDX_CTRL && regwr.strb[0]) begin
			ctrl_nxt[CTRL_RUN_BIT] = regwr.data[CTRL_RUN_BIT];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pc_r      <= PC_RESET;
			latch_r   <= LATCH_RESET;
			ptr_r     <= PTR_RESET;
			res_r     <= '0;
			ctrl_r    <= CTRL_RESET;
			last_ea_r <= '0;
		end else begin
			pc_r      <= pc_nxt;
			latch_r   <= latch_nxt;
			ptr_r     <= ptr_nxt;
			res_r     <= res_nxt;
			ctrl_r    <= ctrl_nxt;
			last_ea_r <= last_ea_nxt;
		end
	end

	// Stack pointer stays hidden: control word, counter, latch, pointer and last address shown
	always_comb begin
		regs               = '0;
		regs[IDX_CTRL]     = ctrl_r;
		regs[IDX_PC_STAT]  = AXI_DW'(pc_r);
		regs[IDX_PC_STAT][STAT_LATCH_LSB +: LATCH_W] = latch_r;
		regs[IDX_PTR_STAT] = AXI_DW'(ptr_r);
		regs[IDX_PTR_STAT][STAT_LAST_LSB +: EA_W] = last_ea_r;
	end

	pcs_axil_regs u_regs (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_awaddr  (i_awaddr),
		.i_awvalid (i_awvalid),
		.o_awready (o_awready),
		.i_wdata   (i_wdata),
		.i_wstrb   (i_wstrb),
		.i_wvalid  (i_wvalid),
		.o_wready  (o_wready),
		.o_bresp   (o_bresp),
		.o_bvalid  (o_bvalid),
		.i_bready  (i_bready),
		.i_araddr  (i_araddr),
		.i_arvalid (i_arvalid),
		.o_arready (o_arready),
		.o_rdata   (o_rdata),
		.o_rresp   (o_rresp),
		.o_rvalid  (o_rvalid),
		.i_rready  (i_rready),
		.i_regs    (regs),
		.o_wr      (regwr)
	);

	assign o_pc  = pc_r;
	assign o_res = res_r;

endmodule // pcs_core

// ===== rtl/pcs_ret_stack.sv
// Purpose: Circular return stack for the program counter.
// Assumes: Push and pop never both asserted in one cycle.
// Notes:   No overflow or underflow indication; the pointer wraps.
`timescale 1ns/1ps
module pcs_ret_stack #(
	parameter int DEPTH = pcs_pkg::STK_DEPTH,
	parameter int PTR_W = pcs_pkg::STK_PTR_W,
	parameter int W     = pcs_pkg::PC_W
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_push,
	input  wire logic         i_pop,
	input  wire logic [W-1:0] i_data,
	output logic      [W-1:0] o_top
);
	import pcs_pkg::*;

	logic [W-1:0]     mem_r   [DEPTH];
	logic [W-1:0]     mem_nxt [DEPTH];
	logic [PTR_W-1:0] ptr_r;
	logic [PTR_W-1:0] ptr_nxt;
	logic [PTR_W-1:0] ptr_dec;

	assign ptr_dec = ptr_r - 1'b1;
	assign o_top   = mem_r[ptr_dec];

	always_comb begin
		mem_nxt = mem_r;
		ptr_nxt = ptr_r;
		if (i_push) begin
			mem_nxt[ptr_r] = i_data;
			ptr_nxt        = ptr_r + 1'b1;
		end else if (i_pop) begin
			ptr_nxt = ptr_dec;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr_r <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else begin
			ptr_r <= ptr_nxt;
			mem_r <= mem_nxt;
		end
	end

endmodule // pcs_ret_stack

// ===== tb/pcs_core_props.sv
// Purpose: Assertions on the counter and data access ports.
// Assumes: BANK_USED left at 0.
// Notes:   Run bit is not visible here, so flow checks allow a hold.
`timescale 1ns/1ps
module pcs_core_props (
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	input  pcs_pkg::pcs_op_type            i_op,
	input  wire logic [pcs_pkg::TGT_W-1:0] i_target,
	input  pcs_pkg::pcs_acc_type           i_acc,
	input  wire logic [pcs_pkg::PC_W-1:0]  o_pc,
	input  pcs_pkg::pcs_res_type           o_res
);
	import pcs_pkg::*;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	logic acc_wr;
	// Any write may hit the low byte indirectly and drop the op
	assign acc_wr = i_acc.valid && i_acc.wr;
	sequence call_s;
		i_op == OP_CALL && !acc_wr;
	endsequence
	sequence ret_s;
		i_op inside {OP_RET, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT} && !acc_wr;
	endsequence
	pc_reset_a: assert property ($rose(i_rst_n) |-> o_pc == PC_RESET)
		else $error("counter not clear after reset");
	goto_page_a: assert property (i_op == OP_GOTO && !acc_wr |=>
		o_pc[10:0] == $past(i_target) || $stable(o_pc))
		else $error("jump target not loaded");
	pc_step_a: assert property (i_op == OP_NEXT && !acc_wr |=>
		o_pc == $past(o_pc) + PC_STEP || $stable(o_pc))
		else $error("counter step wrong");
	irq_vec_a: assert property (i_op == OP_IRQ && !acc_wr |=>
		o_pc == IRQ_VECTOR || $stable(o_pc))
		else $error("interrupt vector wrong");
	low_write_a: assert property (acc_wr &&
		i_acc.addr[6:0] == ADR_PC_LOW |=> o_pc[7:0] == $past(i_acc.wdata))
		else $error("low byte write lost");
	res_timing_a: assert property (i_acc.valid |=>
		o_res.valid && o_res.addr[8] == 1'b0)
		else $error("access answer late or banked");
	self_ind_a: assert property (o_res.valid &&
		o_res.addr[6:0] == 7'h00 |-> o_res.own && !o_res.wr &&
		o_res.rdata == SELF_RDATA)
		else $error("self indirect access not inert");
	call_ret_a: assert property (call_s ##1 ret_s |=>
		o_pc == $past(o_pc, 2))
		else $error("return address wrong");
endmodule // pcs_core_props

bind pcs_core pcs_core_props i_pcs_core_props (
	.i_clk    (i_clk),
	.i_rst_n  (i_rst_n),
	.i_op     (i_op),
	.i_target (i_target),
	.i_acc    (i_acc),
	.o_pc     (o_pc),
	.o_res    (o_res)
);

// ===== tb/pcs_core_tb.sv
// Purpose: Self-checking bench for the counter, stack and indirect port.
// Assumes: Default BANK_USED; bank bit held high to show it is ignored.
// Notes:   Expected counter values are tracked in the bench.
`timescale 1ns/1ps
module pcs_core_tb;
	import pcs_pkg::*;
	logic              i_clk = 1'b0;
	logic              i_rst_n = 1'b0;
	pcs_op_type        i_op;
	logic [TGT_W-1:0]  i_target;
	pcs_acc_type       i_acc;
	logic              i_bank_bit;
	logic [PC_W-1:0]   o_pc;
	pcs_res_type       o_res;
	logic [AXI_AW-1:0] i_awaddr = '0;
	logic [AXI_AW-1:0] i_araddr = '0;
	logic [AXI_DW-1:0] i_wdata = '0;
	logic [AXI_DW-1:0] o_rdata;
	logic [3:0]        i_wstrb = 4'hf;
	logic [1:0]        o_bresp, o_rresp;
	logic              i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic              i_arvalid = 1'b0, i_rready = 1'b0;
	logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [PC_W-1:0]   pc_e;
	int                errors = 0;
	int                n_checks = 0;

	always #2.5 i_clk = ~i_clk;

	pcs_dec_model i_pcs_dec_model (.i_clk(i_clk), .o_op(i_op),
		.o_target(i_target), .o_acc(i_acc), .o_bank_bit(i_bank_bit));
	pcs_core i_pcs_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_op(i_op),
		.i_target(i_target), .i_acc(i_acc), .i_bank_bit(i_bank_bit),
		.o_pc(o_pc), .o_res(o_res), .i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
		.i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.o_rvalid(o_rvalid), .i_rready(i_rready));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic do_op(input pcs_op_type o, input logic [TGT_W-1:0] t);
		i_pcs_dec_model.step(o, t, '0);
		i_pcs_dec_model.step(OP_NONE, '0, '0);
		#1;
	endtask
	task automatic da(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		i_pcs_dec_model.step(OP_NONE, '0, pcs_acc_type'({1'b1, w, a, d}));
		i_pcs_dec_model.step(OP_NONE, '0, '0);
		#1;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] resp);
		logic ap;
		logic wp;
		ap = 1'b1;
		wp = 1'b1;
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (ap || wp) begin
			@(posedge i_clk);
			if (ap && o_awready === 1'b1) begin
				ap = 1'b0;
				i_awvalid <= 1'b0;
			end
			if (wp && o_wready === 1'b1) begin
				wp = 1'b0;
				i_wvalid <= 1'b0;
			end
		end
		while (o_bvalid !== 1'b1) @(posedge i_clk);
		chk(o_bresp, resp);
		i_bready <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a, input logic [1:0] resp,
		input logic [31:0] d);
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do @(posedge i_clk); while (o_arready !== 1'b1);
		i_arvalid <= 1'b0;
		do @(posedge i_clk); while (o_rvalid !== 1'b1);
		chk(o_rresp, resp);
		chk(o_rdata, d);
		i_rready <= 1'b0;
	endtask

	task automatic t_page;
		chk(o_pc, PC_RESET);
		da(1'b1, ADR_LATCH, 8'hff);
		da(1'b0, ADR_LATCH, 8'h00);
		chk(o_res.rdata, 8'h1f);
		do_op(OP_GOTO, 11'h7ff);
		chk(o_pc, 13'h1fff);
		do_op(OP_NEXT, '0);
		chk(o_pc, 13'h0000);
		da(1'b1, ADR_LATCH, 8'h15);
		da(1'b1, ADR_PC_LOW, 8'h5a);
		chk(o_pc, 13'h155a);
		da(1'b0, ADR_PC_LOW, 8'h00);
		chk({o_res.own, o_res.rdata}, 9'h15a);
	endtask
	task automatic t_stack;
		logic [PC_W-1:0] ent [STK_DEPTH];
		logic [PC_W-1:0] p;
		logic [PC_W-1:0] nx;
		pcs_op_type rop [3];
		rop = '{OP_RET, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT};
		da(1'b1, ADR_LATCH, 8'h08);
		do_op(OP_GOTO, 11'h000);
		p = 13'h0800;
		for (int k = 0; k < 9; k++) begin
			nx = (k == 0) ? IRQ_VECTOR : {2'b01, 11'(k * 37)};
			do_op((k == 0) ? OP_IRQ : OP_CALL, 11'(k * 37));
			chk(o_pc, nx);
			ent[k % STK_DEPTH] = p;
			p = nx;
		end
		// New page bit must not leak into returns
		da(1'b1, ADR_LATCH, 8'h10);
		for (int sp = 8; sp >= 0; sp--) begin
			do_op(rop[sp % 3], '0);
			chk(o_pc, ent[sp % STK_DEPTH]);
		end
		i_pcs_dec_model.step(OP_CALL, 11'h123, '0);
		i_pcs_dec_model.step(OP_RET, '0, '0);
		do_op(OP_NONE, '0);
		chk(o_pc, ent[0]);
		da(1'b0, ADR_LATCH, 8'h00);
		chk(o_res.rdata, 8'h10);
		pc_e = ent[0];
	endtask
	task automatic t_indirect;
		da(1'b1, ADR_PTR, 8'h02);
		da(1'b0, ADR_INDIRECT, 8'h00);
		chk({o_res.addr, o_res.rdata}, {9'h002, pc_e[7:0]});
		da(1'b1, ADR_INDIRECT, 8'h34);
		chk(o_pc, 13'h1034);
		da(1'b1, ADR_PTR, 8'h00);
		da(1'b0, ADR_INDIRECT, 8'h00);
		chk({o_res.own, o_res.rdata}, {1'b1, SELF_RDATA});
		da(1'b1, ADR_INDIRECT, 8'h77);
		chk({o_res.wr, o_pc}, {1'b0, 13'h1034});
		da(1'b0, ADR_PTR, 8'h00);
		chk(o_res.rdata, PTR_RESET);
		da(1'b1, ADR_PTR, 8'h20);
		da(1'b0, ADR_INDIRECT, 8'h00);
		chk({o_res.own, o_res.addr}, 10'h020);
	endtask
	task automatic t_bus;
		axr(4'h0, RESP_OKAY, CTRL_RESET);
		axr(4'h4, RESP_OKAY, 32'h0010_1034);
		axr(4'h8, RESP_OKAY, 32'h0000_2020);
		axr(4'hc, RESP_SLVERR, 32'h0);
		axw(4'h4, 32'hffff_ffff, RESP_SLVERR);
		axw(4'h0, 32'h0, RESP_OKAY);
		do_op(OP_GOTO, 11'h7ff);
		chk(o_pc, 13'h1034);
		axw(4'h0, 32'h1, RESP_OKAY);
		do_op(OP_NEXT, '0);
		chk(o_pc, 13'h1035);
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		t_page();
		t_stack();
		t_indirect();
		t_bus();
		complete_run();
	end
	initial begin
		#50000;
		errors++;
		complete_run();
	end
endmodule // pcs_core_tb

// ===== tb/pcs_dec_model.sv
// Purpose: Decoder side model driving flow ops and data accesses.
// Assumes: Called from the bench one step per clock.
// Notes:   Idle lines show inverted data, never the stale value.
`timescale 1ns/1ps
module pcs_dec_model (
	input  wire logic                      i_clk,
	output pcs_pkg::pcs_op_type            o_op,
	output logic [pcs_pkg::TGT_W-1:0]      o_target,
	output pcs_pkg::pcs_acc_type           o_acc,
	output logic                           o_bank_bit
);
	import pcs_pkg::*;
	initial begin
		o_op = OP_NONE;
		o_target = '0;
		o_acc = '0;
		o_bank_bit = 1'b1;
	end
	task automatic step(input pcs_op_type op,
		input logic [TGT_W-1:0] t, input pcs_acc_type a);
		@(posedge i_clk);
		o_op <= op;
		o_target <= (op == OP_GOTO || op == OP_CALL) ? t : ~o_target;
		o_acc <= a.valid ? a : pcs_acc_type'({1'b0, ~o_acc[16:0]});
	endtask
endmodule // pcs_dec_model
